// ---- gtus_top.sv ----
// Group table update semaphore registers with commit tracking
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module gtus_top
  import gtus_pkg::*;
#(
  parameter int GROUPS_PRESENT = VARIANT_GROUPS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Update state per group, toward the datapath
  output logic [NUM_GRP-1:0] tx_upd_en,
  output logic [NUM_GRP-1:0] rx_upd_en,
  // One-cycle commit strobes: adopt rewritten table
  output logic [NUM_GRP-1:0] tx_commit,
  output logic [NUM_GRP-1:0] rx_commit,
  // Sticky: update closed before every element was rewritten
  output logic [NUM_GRP-1:0] tx_partial,
  output logic [NUM_GRP-1:0] rx_partial
);

  // Table index t: 0..15 transmit, 16..31 receive
  logic [NUM_TBL-1:0] upd_en_reg;
  logic [NUM_TBL-1:0] commit_reg;
  logic [NUM_TBL-1:0] partial_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Decode of the flag register bank
  logic sem_hit;
  logic [1:0] sem_idx;
  logic [2:0] bank_ofs;

  // Groups that this variant carries; the rest read as closed
  localparam logic [NUM_GRP-1:0] GRP_MASK = NUM_GRP'((1 << GROUPS_PRESENT) - 1);

  assign bank_ofs = reg_addr[10:8] - BANK_FIRST;
  assign sem_hit = reg_addr[10] && (reg_addr[7:0] == SEM_LOW_OFS);
  assign sem_idx = bank_ofs[1:0];

  // Per table flag, element tracking and commit
  genvar t;
  generate
    for (t = 0; t < NUM_TBL; t++) begin : g_tbl
      localparam int IS_RX = t / NUM_GRP;
      localparam int GRP = t % NUM_GRP;
      localparam int REG = GRP / GRP_PER_REG;
      localparam int POS = GRP % GRP_PER_REG;
      localparam int BIT = (IS_RX != 0) ? RX_FLAG_LSB + POS : TX_FLAG_LSB + POS;
      localparam int LEN = (IS_RX != 0) ? RX_TBL_LEN : TX_TBL_LEN;
      localparam bit PRESENT = GRP < GROUPS_PRESENT;
      localparam logic [7:0] FULL = 8'((1 << LEN) - 1);
      localparam logic [7:0] LOW = (IS_RX != 0) ? RX_TBL_LOW + 8'(POS * LEN) : TX_TBL_LOW + 8'(POS * LEN);
      logic sem_wr;
      logic flag_new;
      logic tbl_hit;
      logic [2:0] elem;
      logic [7:0] seen_reg;

      assign sem_wr = reg_wr && sem_hit && (sem_idx == 2'(REG));
      assign flag_new = PRESENT && reg_wdata[BIT];
      assign tbl_hit = (reg_addr[10:8] == 3'(REG) + BANK_FIRST) && (reg_addr[7:0] >= LOW)
                       && (reg_addr[7:0] < LOW + 8'(LEN));
      assign elem = 3'(reg_addr[7:0] - LOW);

      // Update flag: set or cleared by a write to its register
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          upd_en_reg[t] <= 1'b0;
        end else if (sem_wr) begin
          upd_en_reg[t] <= flag_new;
        end
      end

      // Elements rewritten since the update was opened
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          seen_reg <= 8'h00;
        end else if (sem_wr && flag_new && !upd_en_reg[t]) begin
          seen_reg <= 8'h00;
        end else if (reg_wr && tbl_hit && upd_en_reg[t]) begin
          seen_reg[elem] <= 1'b1;
        end
      end

      // Commit strobe on close: datapath switches to the new table here
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          commit_reg[t] <= 1'b0;
        end else begin
          commit_reg[t] <= sem_wr && upd_en_reg[t] && !flag_new;
        end
      end

      // Partial close flag, cleared when the group is reopened
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          partial_reg[t] <= 1'b0;
        end else if (sem_wr && upd_en_reg[t] && !flag_new) begin
          partial_reg[t] <= (seen_reg != FULL);
        end else if (sem_wr && flag_new && !upd_en_reg[t]) begin
          partial_reg[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read mux: flag registers read as zero, status shows state
  always_comb begin
    rdata_next = RD_IDLE;
    if (reg_addr[10:3] == STAT_HI_OFS) begin
      case (reg_addr[2:0])
        3'd0: rdata_next = upd_en_reg[7:0];
        3'd1: rdata_next = upd_en_reg[15:8];
        3'd2: rdata_next = upd_en_reg[23:16];
        3'd3: rdata_next = upd_en_reg[31:24];
        3'd4: rdata_next = partial_reg[7:0];
        3'd5: rdata_next = partial_reg[15:8];
        3'd6: rdata_next = partial_reg[23:16];
        3'd7: rdata_next = partial_reg[31:24];
        default: rdata_next = RD_IDLE;
      endcase
    end
  end

  // Read data register, valid the cycle after the strobe only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= RD_IDLE;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= RD_IDLE;
    end
  end

  assign reg_rdata = rdata_reg;
  assign tx_upd_en = upd_en_reg[NUM_GRP-1:0];
  assign rx_upd_en = upd_en_reg[NUM_TBL-1:NUM_GRP];
  assign tx_commit = commit_reg[NUM_GRP-1:0];
  assign rx_commit = commit_reg[NUM_TBL-1:NUM_GRP];
  assign tx_partial = partial_reg[NUM_GRP-1:0];
  assign rx_partial = partial_reg[NUM_TBL-1:NUM_GRP];

  // Checks
  property p_sem_read_zero;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && sem_hit) |=> (reg_rdata == RD_IDLE);
  endproperty
  a_sem_read_zero: assert property (p_sem_read_zero) else $error("flag register read not zero");

  property p_tx_low_bank;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_1_TO_4) |=> (tx_upd_en[3:0] == ($past(reg_wdata[3:0]) & GRP_MASK[3:0]));
  endproperty
  a_tx_low_bank: assert property (p_tx_low_bank) else $error("tx flags 1-4 wrong");

  property p_rx_low_bank;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_1_TO_4) |=> (rx_upd_en[3:0] == ($past(reg_wdata[7:4]) & GRP_MASK[3:0]));
  endproperty
  a_rx_low_bank: assert property (p_rx_low_bank) else $error("rx flags 1-4 wrong");

  property p_bank_select;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_9_TO_12) |=>
        (tx_upd_en[11:8] == ($past(reg_wdata[3:0]) & GRP_MASK[11:8])) && $stable(tx_upd_en[7:0])
        && $stable(tx_upd_en[15:12]);
  endproperty
  a_bank_select: assert property (p_bank_select) else $error("wrong bank updated");

  property p_absent_groups;
    @(posedge sys_clk) disable iff (rst)
      (GROUPS_PRESENT < NUM_GRP) |-> (tx_upd_en[NUM_GRP-1] == 1'b0) && (rx_upd_en[NUM_GRP-1] == 1'b0);
  endproperty
  a_absent_groups: assert property (p_absent_groups) else $error("absent group flag set");

  property p_reset_clear;
    @(posedge sys_clk) $fell(rst) |-> (tx_upd_en == '0) && (rx_upd_en == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("flags not clear after reset");

  property p_commit_on_close;
    @(posedge sys_clk) disable iff (rst)
      ($fell(tx_upd_en[0]) |-> tx_commit[0]) and (tx_commit[0] |-> $past(tx_upd_en[0]) && !tx_upd_en[0]);
  endproperty
  a_commit_on_close: assert property (p_commit_on_close) else $error("commit not tied to close");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (rst)
      (rx_upd_en[5] && !(reg_wr && reg_addr == SEM_OFS_5_TO_8)) |=> rx_upd_en[5] ##0 !rx_commit[5];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("open flag dropped without write");

  property p_partial_close;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_13_TO_16 && !reg_wdata[7] && rx_upd_en[15]) |=>
        (rx_partial[15] == ($past(g_tbl[31].seen_reg) != 8'h0f));
  endproperty
  a_partial_close: assert property (p_partial_close) else $error("partial flag wrong on close");

  property p_read_one_cycle;
    @(posedge sys_clk) disable iff (rst)
      !reg_rd |=> (reg_rdata == RD_IDLE);
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data outside its cycle");

  property p_stat_tx_open;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == STAT_TX_OPEN_LO) |=> (reg_rdata == $past(tx_upd_en[7:0]));
  endproperty
  a_stat_tx_open: assert property (p_stat_tx_open) else $error("open status read wrong");

  property p_stat_partial;
    @(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == STAT_PARTIAL_LO) |=> (reg_rdata == $past(tx_partial[7:0]));
  endproperty
  a_stat_partial: assert property (p_stat_partial) else $error("partial status read wrong");

  property p_tx_mid_bank;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_5_TO_8) |=> (tx_upd_en[7:4] == ($past(reg_wdata[3:0]) & GRP_MASK[7:4]));
  endproperty
  a_tx_mid_bank: assert property (p_tx_mid_bank) else $error("tx flags 5-8 wrong");

  property p_rx_mid_bank;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_5_TO_8) |=> (rx_upd_en[7:4] == ($past(reg_wdata[7:4]) & GRP_MASK[7:4]));
  endproperty
  a_rx_mid_bank: assert property (p_rx_mid_bank) else $error("rx flags 5-8 wrong");

  property p_rx_bank_select;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_13_TO_16) |=>
        (rx_upd_en[15:12] == ($past(reg_wdata[7:4]) & GRP_MASK[15:12])) && $stable(rx_upd_en[11:0]);
  endproperty
  a_rx_bank_select: assert property (p_rx_bank_select) else $error("wrong rx bank updated");

  property p_flags_keep;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr[7:0] != SEM_LOW_OFS) |=> $stable(tx_upd_en) && $stable(rx_upd_en);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("flag moved on other write");

  property p_absent_mask;
    @(posedge sys_clk) disable iff (rst)
      ((tx_upd_en & ~GRP_MASK) == '0) && ((rx_upd_en & ~GRP_MASK) == '0);
  endproperty
  a_absent_mask: assert property (p_absent_mask) else $error("flag of absent group set");

  property p_reset_outputs;
    @(posedge sys_clk) $fell(rst) |->
      (tx_commit == '0) && (rx_commit == '0) && (tx_partial == '0) && (rx_partial == '0);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not clear after reset");

  property p_commit_one_cycle;
    @(posedge sys_clk) disable iff (rst)
      tx_commit[3] |=> !tx_commit[3];
  endproperty
  a_commit_one_cycle: assert property (p_commit_one_cycle) else $error("commit longer than a cycle");

  property p_no_commit_open;
    @(posedge sys_clk) disable iff (rst)
      tx_upd_en[0] |-> !tx_commit[0];
  endproperty
  a_no_commit_open: assert property (p_no_commit_open) else $error("commit while update open");

  property p_rx_commit_close;
    @(posedge sys_clk) disable iff (rst)
      $fell(rx_upd_en[5]) |-> rx_commit[5];
  endproperty
  a_rx_commit_close: assert property (p_rx_commit_close) else $error("rx close without commit");

  property p_rx_commit_only;
    @(posedge sys_clk) disable iff (rst)
      rx_commit[5] |-> $past(rx_upd_en[5]) && !rx_upd_en[5];
  endproperty
  a_rx_commit_only: assert property (p_rx_commit_only) else $error("rx commit without close");

  property p_partial_sticky;
    @(posedge sys_clk) disable iff (rst)
      (tx_partial[6] && !(reg_wr && reg_addr == SEM_OFS_5_TO_8)) |=> tx_partial[6];
  endproperty
  a_partial_sticky: assert property (p_partial_sticky) else $error("partial flag dropped");

  property p_full_close_clean;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_1_TO_4 && !reg_wdata[0] && tx_upd_en[0] && g_tbl[0].seen_reg == 8'hff)
        |=> !tx_partial[0];
  endproperty
  a_full_close_clean: assert property (p_full_close_clean) else $error("full rewrite marked partial");

  property p_reopen_clears;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_1_TO_4 && reg_wdata[0] && !tx_upd_en[0]) |=> !tx_partial[0];
  endproperty
  a_reopen_clears: assert property (p_reopen_clears) else $error("reopen kept partial flag");

  property p_reopen_forgets;
    @(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == SEM_OFS_1_TO_4 && reg_wdata[0] && !tx_upd_en[0]) |=> (g_tbl[0].seen_reg == 8'h00);
  endproperty
  a_reopen_forgets: assert property (p_reopen_forgets) else $error("reopen kept element record");

endmodule // gtus_top

// ---- gtus_pkg.sv ----
// Constants for the group table update semaphore bank
// Summary of operation
// - Flag at one means table under update; zero means not under update.
// - The four flag registers are write-only; reads of them return zero.
// - Bits 3 to 0 open four consecutive transmit tables, lowest group at bit 0.
// - Bits 7 to 4 open four consecutive receive tables, lowest group at bit 4.
// - The four registers cover groups 1-4, 5-8, 9-12 and 13-16 in turn.
// - Flags of groups the variant lacks do not exist and stay at zero.
// - Every flag clears on reset, so no table is under update afterwards.
package gtus_pkg;
  // Bus and bank shape
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int NUM_GRP = 16;
  localparam int GRP_PER_REG = 4;
  localparam int NUM_TBL = 2 * NUM_GRP;
  // Flag register offsets: bank number in addr[10:8], low byte fixed
  localparam logic [2:0] BANK_FIRST = 3'h4;
  localparam logic [7:0] SEM_LOW_OFS = 8'h1f;
  // The four semaphore registers, one per bank, sit at these addresses
  localparam logic [10:0] SEM_OFS_1_TO_4 = 11'h41f;
  localparam logic [10:0] SEM_OFS_5_TO_8 = 11'h51f;
  localparam logic [10:0] SEM_OFS_9_TO_12 = 11'h61f;
  localparam logic [10:0] SEM_OFS_13_TO_16 = 11'h71f;
  localparam logic [7:0] SEM_RESET = 8'h00;
  // Field positions inside a flag register
  localparam int TX_FLAG_LSB = 0;
  localparam int RX_FLAG_LSB = 4;
  // Group table windows (low byte within a bank) and lengths
  localparam logic [7:0] TX_TBL_LOW = 8'h20;
  localparam logic [7:0] RX_TBL_LOW = 8'hd0;
  localparam int TX_TBL_LEN = 8;
  localparam int RX_TBL_LEN = 4;
  // Status registers: open flags then partial-close flags, 8 groups a byte
  localparam logic [7:0] STAT_HI_OFS = 8'hfe;
  localparam logic [10:0] STAT_TX_OPEN_LO = 11'h7f0;
  localparam logic [10:0] STAT_PARTIAL_LO = 11'h7f4;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
  // Largest variant carries all sixteen groups
  localparam int VARIANT_GROUPS = 16;
endpackage

// ---- gtus_top_test.sv ----
// Self-checking testbench for the group table update semaphore bank
`timescale 1ns/1ps
module gtus_top_test
  import gtus_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_GRP-1:0] tx_upd_en, rx_upd_en, tx_commit, rx_commit, tx_partial, rx_partial;
  logic [NUM_GRP-1:0] tx_upd_en_s, rx_upd_en_s, tc, rc;
  logic [7:0] rv;
  int num_errors = 0;
  int check_count = 0;

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  // Full variant under test
  gtus_top uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_upd_en(tx_upd_en),
    .rx_upd_en(rx_upd_en), .tx_commit(tx_commit), .rx_commit(rx_commit),
    .tx_partial(tx_partial), .rx_partial(rx_partial));

  // Small variant with two groups shares the same register port
  gtus_top #(.GROUPS_PRESENT(2)) uut_small (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .tx_upd_en(tx_upd_en_s),
    .rx_upd_en(rx_upd_en_s), .tx_commit(), .rx_commit(), .tx_partial(), .rx_partial());

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write cycle; commit strobes captured in the cycle after it
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
    tc = tx_commit;
    rc = rx_commit;
  endtask

  // One read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic t_reset();
    chk(tx_upd_en, 16'h0000);
    chk(rx_upd_en, 16'h0000);
    chk(tx_partial | rx_partial | tx_commit | rx_commit, 16'h0000);
    rd(11'h41f, rv);
    chk({8'h00, rv}, 16'h0000);
    $display("reset test done");
  endtask

  // Each bank drives its own four groups; flags never read back
  task automatic t_map();
    logic [7:0] d;
    logic [10:0] a;
    for (int b = 0; b < 4; b++) begin
      d = b[0] ? 8'h24 : 8'h81;
      a = {3'(4 + b), 8'h1f};
      wr(a, d);
      chk(tx_upd_en, {12'h000, d[3:0]} << (4 * b));
      chk(rx_upd_en, {12'h000, d[7:4]} << (4 * b));
      rd(a, rv);
      chk({8'h00, rv}, 16'h0000);
      wr(a, 8'h00);
      chk(tx_upd_en | rx_upd_en, 16'h0000);
    end
    wr(11'h41e, 8'hff);
    chk(tx_upd_en | rx_upd_en, 16'h0000);
    $display("map test done");
  endtask

  // Complete rewrite of transmit group 1 commits cleanly
  task automatic t_full();
    wr(11'h41f, 8'h01);
    for (int i = 0; i < 8; i++) wr(11'h420 + 11'(i), 8'(i));
    chk(tc, 16'h0000);
    wr(11'h41f, 8'h00);
    chk(tc, 16'h0001);
    chk(tx_partial, 16'h4140);
    @(posedge sys_clk);
    #1;
    chk(tx_commit, 16'h0000);
    $display("full update test done");
  endtask

  // Receive group 6 closed after three of four elements
  task automatic t_part();
    wr(11'h51f, 8'h20);
    for (int i = 0; i < 3; i++) wr(11'h5d4 + 11'(i), 8'hff);
    wr(11'h51f, 8'h00);
    chk(rc, 16'h0020);
    chk(rx_partial, 16'h2828);
    rd(11'h7f6, rv);
    chk({8'h00, rv}, 16'h0028);
    $display("partial update test done");
  endtask

  // Absent groups keep their flags at zero
  task automatic t_variant();
    wr(11'h41f, 8'hff);
    chk(tx_upd_en_s, 16'h0003);
    chk(rx_upd_en_s, 16'h0003);
    chk(tx_upd_en, 16'h000f);
    wr(11'h51f, 8'hff);
    chk(tx_upd_en_s | rx_upd_en_s, 16'h0003);
    rd(11'h7f2, rv);
    chk({8'h00, rv}, 16'h00ff);
    @(posedge sys_clk);
    #1;
    chk({8'h00, reg_rdata}, 16'h0000);
    $display("variant test done");
  endtask

  // Counts and verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog at 5000 cycles, far beyond the under one hundred cycles the tests need
  initial begin
    #(25 * 5000);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_map();
    t_full();
    t_part();
    t_variant();
    end_sim();
  end
endmodule // gtus_top_test
